// *** logic/avf_pkg.sv ***
// package: command codes, field layout, reset values and carriers of the alert mask and voltage format bank
package avf_pkg;

    // ==========================================================
    // command codes
    localparam logic [7:0] CMD_ALERT_MASK = 8'h1B;
    localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20;
    localparam logic [7:0] CMD_VOUT_SETPOINT = 8'h21;

    // ==========================================================
    // status register codes that select a mask byte
    localparam logic [7:0] STAT_INPUT = 8'h7C;
    localparam logic [7:0] STAT_TEMPERATURE = 8'h7D;
    localparam logic [7:0] STAT_COMM_LOGIC = 8'h7E;
    localparam logic [7:0] STAT_OTHER = 8'h7F;
    localparam logic [7:0] STAT_VENDOR = 8'h80;

    // mask slot indices
    localparam int MASK_COUNT = 5;
    localparam logic [2:0] IDX_INPUT = 3'h0;
    localparam logic [2:0] IDX_TEMPERATURE = 3'h1;
    localparam logic [2:0] IDX_COMM_LOGIC = 3'h2;
    localparam logic [2:0] IDX_OTHER = 3'h3;
    localparam logic [2:0] IDX_VENDOR = 3'h4;

    // ==========================================================
    // voltage format field layout and mode codes
    localparam int FMT_MODE_MSB = 7;
    localparam int FMT_MODE_LSB = 5;
    localparam int FMT_PARAM_MSB = 4;
    localparam int FMT_PARAM_LSB = 0;
    localparam logic [2:0] MODE_LINEAR = 3'h0;
    localparam logic [2:0] MODE_VID = 3'h1;
    localparam logic [2:0] MODE_DIRECT = 3'h2;
    localparam logic [4:0] DIRECT_PARAM = 5'h00;

    // setpoint is scaled to units of 2^-11 V
    localparam logic signed [6:0] SETPOINT_FRAC_BITS = 7'sh0B;

    // ==========================================================
    // reset values
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] VOUT_FORMAT_RESET = 8'h15;
    localparam logic [15:0] VOUT_SETPOINT_RESET = 16'h0000;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [7:0] target;
        logic [15:0] wdata;
    } avf_cmd_t;

    typedef struct packed {
        logic valid;
        logic error;
        logic [15:0] rdata;
    } avf_rsp_t;

    typedef struct packed {
        logic [2:0] mode;
        logic [4:0] param;
    } avf_format_t;

endpackage : avf_pkg

// *** logic/avf_regs.sv ***
// alert mask bytes, output voltage format register and setpoint interpretation
// How it works
// - all five masks share command 0x1B; the target status code picks the byte
// - mask bit 0 lets its status bit pull alert, 1 ignores it
// - each of eight mask bits gates the status bit at the same position
// - target code 0x7C selects the input status mask
// - target code 0x7D selects the temperature status mask
// - target code 0x7E selects the communication, memory and logic mask
// - target code 0x7F selects the other-conditions mask
// - target code 0x80 selects the vendor-specific status mask
// - format register 0x20 governs how the stored setpoint is read, including one written before the format
// - format bits 7:5 pick linear 000, VID 001 or direct 010
// - linear mode: bits 4:0 are a signed exponent applied to mantissa
// - VID mode: bits 4:0 carry a VID code identifier, not an exponent
// - direct mode: low five format bits always hold zero
// - sixteen-bit setpoint is unsigned mantissa, exponent minus eleven by default
`timescale 1ns/10ps
`default_nettype none

module avf_regs (
    input wire logic ref_clk,
    input wire logic rst,
    input wire avf_pkg::avf_cmd_t cmd,
    input wire logic [avf_pkg::MASK_COUNT-1:0][7:0] status_bytes,
    output avf_pkg::avf_rsp_t rsp,
    output logic alert_output_n,
    output logic [2:0] vout_mode,
    output logic [4:0] vout_param,
    output logic [31:0] vout_setpoint_scaled,
    output logic vout_setpoint_sat,
    output logic vout_update
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [avf_pkg::MASK_COUNT-1:0][7:0] mask;
        avf_pkg::avf_format_t fmt;
        logic [15:0] setpoint;
        logic [31:0] scaled;
        logic sat;
        logic update;
        logic alert_n;
        avf_pkg::avf_rsp_t rsp;
    } avf_state_t;

    avf_state_t st;
    avf_state_t next_st;

    // ==========================================================
    // helpers
    // maps a status register code to its mask slot; hit is low for unknown codes
    function automatic logic [3:0] avf_mask_slot(input logic [7:0] code);
        logic [3:0] r;
        r = 4'h0;
        unique case (code)
            avf_pkg::STAT_INPUT: r = {1'b1, avf_pkg::IDX_INPUT};
            avf_pkg::STAT_TEMPERATURE: r = {1'b1, avf_pkg::IDX_TEMPERATURE};
            avf_pkg::STAT_COMM_LOGIC: r = {1'b1, avf_pkg::IDX_COMM_LOGIC};
            avf_pkg::STAT_OTHER: r = {1'b1, avf_pkg::IDX_OTHER};
            avf_pkg::STAT_VENDOR: r = {1'b1, avf_pkg::IDX_VENDOR};
            default: r = 4'h0;
        endcase
        return r;
    endfunction : avf_mask_slot

    // scales a mantissa by 2^exp into units of 2^-11 V, saturating at 32 bits
    function automatic logic [32:0] avf_scale(input logic [15:0] mant, input logic [4:0] expo);
        logic signed [6:0] sh;
        logic [47:0] wide;
        logic [32:0] r;
        sh = $signed({{2{expo[4]}}, expo}) + avf_pkg::SETPOINT_FRAC_BITS;
        wide = {32'h0, mant};
        if (sh >= 7'sh00) begin
            wide = wide << sh[5:0];
        end else begin
            wide = wide >> 6'((-sh));
        end
        if (wide[47:32] != 16'h0000) begin
            r = {1'b1, 32'hFFFFFFFF};
        end else begin
            r = {1'b0, wide[31:0]};
        end
        return r;
    endfunction : avf_scale

    // ==========================================================
    // next state
    logic [3:0] slot;
    logic [7:0] pending;
    logic [32:0] scaled_full;
    avf_pkg::avf_format_t wfmt;
    logic fmt_ok;

    always_comb begin
        next_st = st;
        next_st.update = 1'b0;
        next_st.rsp = '0;
        slot = avf_mask_slot(cmd.target);
        wfmt = cmd.wdata[7:0];
        // reserved mode codes are refused so the format never holds an unknown mode
        fmt_ok = (wfmt.mode == avf_pkg::MODE_LINEAR)
            || (wfmt.mode == avf_pkg::MODE_VID)
            || (wfmt.mode == avf_pkg::MODE_DIRECT && wfmt.param == avf_pkg::DIRECT_PARAM);

        if (cmd.valid) begin
            next_st.rsp.valid = 1'b1;
            unique case (cmd.code)
                avf_pkg::CMD_ALERT_MASK: begin
                    if (!slot[3]) begin
                        next_st.rsp.error = 1'b1;
                    end else if (cmd.write) begin
                        next_st.mask[slot[2:0]] = cmd.wdata[7:0];
                    end else begin
                        next_st.rsp.rdata = {8'h00, st.mask[slot[2:0]]};
                    end
                end
                avf_pkg::CMD_VOUT_FORMAT: begin
                    if (!cmd.write) begin
                        next_st.rsp.rdata = {8'h00, st.fmt};
                    end else if (fmt_ok) begin
                        next_st.fmt = wfmt;
                    end else begin
                        next_st.rsp.error = 1'b1;
                    end
                end
                avf_pkg::CMD_VOUT_SETPOINT: begin
                    if (cmd.write) begin
                        next_st.setpoint = cmd.wdata;
                        next_st.update = 1'b1;
                    end else begin
                        next_st.rsp.rdata = st.setpoint;
                    end
                end
                default: next_st.rsp.error = 1'b1;
            endcase
        end

        // setpoint is read with the format in force now, so a format change rescales it
        if (st.fmt.mode == avf_pkg::MODE_LINEAR) begin
            scaled_full = avf_scale(st.setpoint, st.fmt.param);
        end else begin
            // VID code and direct coefficients are resolved downstream; the raw word passes
            scaled_full = {17'h00000, st.setpoint};
        end
        next_st.scaled = scaled_full[31:0];
        next_st.sat = scaled_full[32];

        pending = 8'h00;
        for (int i = 0; i < avf_pkg::MASK_COUNT; i++) begin
            pending = pending | (status_bytes[i] & ~st.mask[i]);
        end
        // level follows the status: released as soon as no unmasked bit remains
        next_st.alert_n = ~(|pending);
    end

    // ==========================================================
    // registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st.mask <= {avf_pkg::MASK_COUNT{avf_pkg::MASK_RESET}};
            st.fmt <= avf_pkg::VOUT_FORMAT_RESET;
            st.setpoint <= avf_pkg::VOUT_SETPOINT_RESET;
            st.scaled <= 32'h00000000;
            st.sat <= 1'b0;
            st.update <= 1'b0;
            st.alert_n <= 1'b1;
            st.rsp <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rsp = st.rsp;
    assign alert_output_n = st.alert_n;
    assign vout_mode = st.fmt.mode;
    assign vout_param = st.fmt.param;
    assign vout_setpoint_scaled = st.scaled;
    assign vout_setpoint_sat = st.sat;
    assign vout_update = st.update;

endmodule : avf_regs

`default_nettype wire

// *** test/avf_host.sv ***
// host bus controller model: issues one command and takes its answer
`timescale 1ns/10ps
`default_nettype none

module avf_host (
    input wire logic ref_clk,
    input wire avf_pkg::avf_rsp_t rsp,
    output var avf_pkg::avf_cmd_t cmd
);
    initial cmd = '0;
    task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] t, input logic [15:0] d,
        output avf_pkg::avf_rsp_t r);
        @(posedge ref_clk);
        #1 cmd = {1'b1, w, c, t, d};
        @(posedge ref_clk);
        #1 r = rsp;
        // released fields show the inverse so stale values are never mistaken for live ones
        cmd = {1'b0, ~w, ~c, ~t, ~d};
    endtask : xfer
endmodule : avf_host

`default_nettype wire

// *** test/avf_regs_sva.sv ***
// checker: command answers, format legality and alert relations of the register bank
`timescale 1ns/10ps
`default_nettype none

module avf_regs_sva (
    input wire logic ref_clk,
    input wire logic rst,
    input wire avf_pkg::avf_cmd_t cmd,
    input wire logic [avf_pkg::MASK_COUNT-1:0][7:0] status_bytes,
    input wire avf_pkg::avf_rsp_t rsp,
    input wire logic alert_output_n,
    input wire logic [2:0] vout_mode,
    input wire logic [4:0] vout_param,
    input wire logic vout_update
);
    // ==========
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    logic wr_fmt;
    logic wr_ok;
    assign wr_fmt = cmd.valid && cmd.write && cmd.code == avf_pkg::CMD_VOUT_FORMAT;
    // only linear, vid and direct with zero low bits are legal
    assign wr_ok = cmd.wdata[7:5] < 3'h2 || cmd.wdata[7:0] == 8'h40;
    a_rsp_latency: assert property (cmd.valid |=> rsp.valid)
        else $error("no answer after command");
    a_bad_target: assert property (cmd.valid && cmd.code == avf_pkg::CMD_ALERT_MASK &&
        !(cmd.target inside {[avf_pkg::STAT_INPUT:avf_pkg::STAT_VENDOR]}) |=> rsp.error)
        else $error("bad mask target accepted");
    a_fmt_refuse: assert property (wr_fmt && !wr_ok |=> rsp.error && $stable({vout_mode, vout_param}))
        else $error("illegal format taken");
    a_fmt_write: assert property (wr_fmt && wr_ok |=> {vout_mode, vout_param} == $past(cmd.wdata[7:0]))
        else $error("format not stored");
    a_mode_legal: assert property (vout_mode <= avf_pkg::MODE_DIRECT)
        else $error("reserved mode held");
    a_direct_zero: assert property (vout_mode == avf_pkg::MODE_DIRECT |-> vout_param == 5'h00)
        else $error("direct mode low bits set");
    a_alert_quiet: assert property (status_bytes == '0 |=> alert_output_n)
        else $error("alert without status");
    a_alert_cause: assert property ($fell(alert_output_n) |-> $past(|status_bytes))
        else $error("alert fell without cause");
    a_update_pulse: assert property (cmd.valid && cmd.write && cmd.code == avf_pkg::CMD_VOUT_SETPOINT
        |=> vout_update)
        else $error("no setpoint update");
    c_alert: cover property (!alert_output_n);
    c_error: cover property (rsp.error);
    c_update: cover property (vout_update);
endmodule : avf_regs_sva

bind avf_regs avf_regs_sva u_sva (.ref_clk, .rst, .cmd, .status_bytes, .rsp, .alert_output_n, .vout_mode,
    .vout_param, .vout_update);

`default_nettype wire

// *** test/avf_regs_tb.sv ***
// testbench: mask bank, format register, setpoint scaling and alert gating
`timescale 1ns/10ps
`default_nettype none

module avf_regs_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [avf_pkg::MASK_COUNT-1:0][7:0] status_bytes = '0;
    avf_pkg::avf_cmd_t cmd;
    avf_pkg::avf_rsp_t rsp;
    avf_pkg::avf_rsp_t r;
    logic alert_output_n;
    logic vout_update;
    logic [2:0] vout_mode;
    logic [4:0] vout_param;
    logic [31:0] vout_setpoint_scaled;
    logic vout_setpoint_sat;
    logic [7:0] ex;
    logic [7:0] fv [5] = '{8'h00, 8'h2A, 8'h40, 8'h41, 8'h60};
    int n_errors = 0;
    int checks = 0;
    avf_regs u_dut (.ref_clk, .rst, .cmd, .status_bytes, .rsp, .alert_output_n, .vout_mode, .vout_param,
        .vout_setpoint_scaled, .vout_setpoint_sat, .vout_update);
    avf_host u_host (.ref_clk, .rsp, .cmd);
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude;
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    // ==========
    initial begin
        #1000000;
        n_errors++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            u_host.xfer(1'b0, avf_pkg::CMD_ALERT_MASK, 8'h7C + 8'(i), 16'h0000, r);
            chk({r.valid, r.rdata}, 32'h10000);
            u_host.xfer(1'b1, avf_pkg::CMD_ALERT_MASK, 8'h7C + 8'(i), {8'hA5, 8'h10 + 8'(i)}, r);
        end
        // read back after all writes so aliased slots would show
        for (int i = 0; i < 5; i++) begin
            u_host.xfer(1'b0, avf_pkg::CMD_ALERT_MASK, 8'h7C + 8'(i), 16'h0000, r);
            chk(r.rdata, 32'h10 + i);
        end
        u_host.xfer(1'b0, avf_pkg::CMD_ALERT_MASK, 8'h7B, 16'h0000, r);
        chk({r.error, r.rdata}, 32'h10000);
        u_host.xfer(1'b0, avf_pkg::CMD_VOUT_FORMAT, 8'h00, 16'h0000, r);
        chk(r.rdata, 32'h15);
        for (int i = 0; i < 5; i++) begin
            u_host.xfer(1'b1, avf_pkg::CMD_VOUT_FORMAT, 8'h00, {8'h00, fv[i]}, r);
            chk(r.error, i > 2);
            if (i < 3) ex = fv[i];
            tick();
            chk({vout_mode, vout_param}, ex);
        end
        u_host.xfer(1'b1, avf_pkg::CMD_VOUT_FORMAT, 8'h00, 16'h0015, r);
        u_host.xfer(1'b1, avf_pkg::CMD_VOUT_SETPOINT, 8'h00, 16'h6400, r);
        chk(vout_update, 1'b1);
        tick();
        chk(vout_setpoint_scaled, 32'h6400);
        chk(vout_setpoint_sat, 1'b0);
        u_host.xfer(1'b1, avf_pkg::CMD_VOUT_FORMAT, 8'h00, 16'h0016, r);
        tick();
        chk(vout_setpoint_scaled, 32'hC800);
        u_host.xfer(1'b1, avf_pkg::CMD_VOUT_FORMAT, 8'h00, 16'h0014, r);
        tick();
        chk(vout_setpoint_scaled, 32'h3200);
        // exponent +15 pushes the mantissa past 32 bits
        u_host.xfer(1'b1, avf_pkg::CMD_VOUT_FORMAT, 8'h00, 16'h000F, r);
        tick();
        chk({vout_setpoint_sat, vout_setpoint_scaled}, 33'h1FFFFFFFF);
        u_host.xfer(1'b1, avf_pkg::CMD_VOUT_FORMAT, 8'h00, 16'h0020, r);
        tick();
        chk(vout_setpoint_scaled, 32'h6400);
        chk(vout_setpoint_sat, 1'b0);
        for (int j = 0; j < 8; j++) begin
            status_bytes[2] = 8'h01 << j;
            u_host.xfer(1'b1, avf_pkg::CMD_ALERT_MASK, avf_pkg::STAT_COMM_LOGIC, {8'h00, ~(8'h01 << j)}, r);
            tick();
            chk(alert_output_n, 1'b0);
            u_host.xfer(1'b1, avf_pkg::CMD_ALERT_MASK, avf_pkg::STAT_COMM_LOGIC, {8'h00, 8'h01 << j}, r);
            tick();
            chk(alert_output_n, 1'b1);
        end
        conclude();
    end
endmodule : avf_regs_tb

`default_nettype wire
